// ===== verilog/wkpme_pkg.sv
// Constants, register map and types of the wake event and PME block.
// Assumes a single 250 MHz clock domain and a plain register port.
package wkpme_pkg;

  // ---------------------------------------------------------------------
  // Register offsets (byte addresses).
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_OP_MODE = 8'h30;
  localparam logic [7:0] ADDR_DEV_CFG = 8'h40;
  localparam logic [7:0] ADDR_POWER_CTRL_STATUS_REG = 8'h54;
  localparam logic [7:0] ADDR_PORT_SEL = 8'h68;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h70;

  // ---------------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------------
  localparam logic [31:0] DEV_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] OP_MODE_RST = 32'h0000_0000;
  localparam logic [31:0] PORT_SEL_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------
  localparam int PM_STATE_LSB = 0;
  localparam int PM_EN_BIT = 8;
  localparam int PM_STATUS_BIT = 15;
  localparam int CFG_PKT_BIT = 27;
  localparam int CFG_FRAME_BIT = 28;
  localparam int CFG_LINK_BIT = 29;
  localparam int OPM_LSB = 25;
  localparam int PSEL_LSB = 3;
  localparam int DIAG_CLR_TX_WP = 0;
  localparam int DIAG_CLR_TX_RP = 1;
  localparam int DIAG_CLR_RX_WP = 2;
  localparam int DIAG_CLR_RX_RP = 3;
  localparam int DIAG_SET_TX_WP = 5;
  localparam int DIAG_SET_RX_WP = 6;

  // ---------------------------------------------------------------------
  // Codes and sizes.
  // ---------------------------------------------------------------------
  localparam logic [3:0] OPM_FIFO_TEST = 4'h3;
  localparam logic [5:0] PORT_TX = 6'h32;
  localparam logic [5:0] PORT_RX = 6'h35;
  localparam logic [5:0] PORT_DIAG = 6'h38;
  localparam logic [7:0] PTR_HALF = 8'h80;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] FRAME_BYTES = 8'h80;
  localparam int FRAMES = 8;
  localparam int MEM_WORDS = 256;
  localparam logic [1:0] MASK_CMP = 2'b01;
  localparam logic [1:0] MASK_END = 2'b11;

  typedef enum logic [1:0] {
    WKPME_D0 = 2'b00,
    WKPME_D3HOT = 2'b11
  } wkpme_pstate_e;

endpackage

// ===== verilog/wkpme_frame_match.sv
// One sample frame comparator of the wake event block.
// Assumes bytes, sample bytes and mask codes arrive aligned on mclk.
`timescale 1ns/1ps
module wkpme_frame_match (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Received byte stream and sample store.
  input wire logic start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [7:0] sample_data,
  input wire logic [1:0] mask_code,
  input wire logic length_over,
  input wire logic packet_end,
  // Result.
  output logic hit
);
  import wkpme_pkg::*;

  typedef struct packed {
    logic active;
    logic ok;
    logic hit;
  } wkpme_match_s;

  wkpme_match_s s;
  wkpme_match_s next_s;

  always_comb begin
    next_s = s;
    next_s.hit = 1'b0;
    if (start) begin
      next_s.active = 1'b1;
      next_s.ok = 1'b1;
    end else if (s.active) begin
      if (byte_valid) begin
        if (length_over || mask_code == MASK_END) begin
          next_s.hit = s.ok;
          next_s.active = 1'b0;
        end else if (mask_code == MASK_CMP && byte_data != sample_data) begin
          next_s.ok = 1'b0;
        end
      end
      // A packet shorter than its sample ends the compare with no match.
      if (packet_end && next_s.active) begin
        next_s.active = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hit = s.hit;

endmodule

// ===== verilog/wkpme_top.sv
// Power state, wake event and PME request logic with the sample store.
// Assumes the receive path runs on mclk and flags wake packets itself.
// Operation
// - Only full-function and hot/cold low-power states; intermediate ones are refused.
// - In hot low power, registers answer and wake detection stays active.
// - Cold state keeps the PME circuit and wake detection alive on aux power.
// - On power return the system resets; reset brings the full-function state.
// - PME request is an active-low open-drain pin, asynchronous to the bus.
// - PME stays asserted until wake enable clears or status is written one.
// - Link change, wake packet or sample-frame match raise PME when enabled.
// - Config bit 29 makes any link status change a wake event.
// - Config bit 27 or a nonvolatile setting enables wake-packet detection.
// - Config bit 28 enables sample-frame wake matching.
// - Sample data in receive store, masks in transmit store, test mode only.
// - Comparison ends past the sample length or when the packet ends.
// - Eight sample frames of up to 128 bytes each.
// - Mask bits 01 compare, 11 ends the sample, 00 and 10 ignore.
// - Port select codes 32h, 35h and 38h pick transmit, receive, pointer ports.
// - Pointer port bits clear each pointer or preset the two write pointers; bit 4 does nothing.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module wkpme_top (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rd_data,
  // Receive path.
  input wire logic link_status,
  input wire logic nv_wake_packet_en,
  input wire logic wake_packet_hit,
  input wire logic rx_start,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  // Power management.
  output wkpme_pkg::wkpme_pstate_e power_state,
  output logic pme_n_out,
  output logic pme_n_oe
);
  import wkpme_pkg::*;

  // -----------------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------------
  typedef struct packed {
    wkpme_pstate_e pstate;
    logic wake_en;
    logic wake_status;
    logic [31:0] dev_cfg;
    logic [31:0] op_mode;
    logic [31:0] port_sel;
    logic [6:0] diag;
    logic [7:0] tx_wp;
    logic [7:0] tx_rp;
    logic [7:0] rx_wp;
    logic [7:0] rx_rp;
    logic [MEM_WORDS-1:0][31:0] tx_mem;
    logic [MEM_WORDS-1:0][31:0] rx_mem;
    logic link_meta;
    logic link_sync;
    logic link_prev;
    logic link_primed;
    logic [7:0] rx_idx;
    logic [31:0] rd_data;
    logic pme_out;
    logic pme_oe;
  } wkpme_state_s;

  wkpme_state_s s;
  wkpme_state_s next_s;
  logic [FRAMES-1:0] frame_hit;
  logic fifo_test;
  logic [5:0] port;
  logic link_change;
  logic pkt_en;
  logic frame_en;
  logic wake_event;
  logic length_over;

  assign fifo_test = s.op_mode[OPM_LSB+3:OPM_LSB] == OPM_FIFO_TEST;
  assign port = s.port_sel[PSEL_LSB+5:PSEL_LSB];
  assign pkt_en = s.dev_cfg[CFG_PKT_BIT] | nv_wake_packet_en;
  assign frame_en = s.dev_cfg[CFG_FRAME_BIT];
  assign length_over = s.rx_idx == FRAME_BYTES;
  assign link_change = s.link_primed && (s.link_sync != s.link_prev);

  // -----------------------------------------------------------------------
  // Sample frame comparators.
  // -----------------------------------------------------------------------
  // Each frame reads its byte lane of the word picked by the byte index.
  for (genvar f = 0; f < FRAMES; f++) begin : g_frame
    localparam logic HALF = 1'(f / 4);
    localparam int LANE = f % 4;
    logic [7:0] word_idx;
    assign word_idx = {HALF, s.rx_idx[6:0]};
    wkpme_frame_match u_match (
      .mclk(mclk),
      .rst(rst),
      .start(rx_start & frame_en),
      .byte_valid(rx_valid),
      .byte_data(rx_data),
      .sample_data(s.rx_mem[word_idx][8*LANE +: 8]),
      .mask_code(s.tx_mem[word_idx][8*LANE +: 2]),
      .length_over(length_over),
      .packet_end(rx_end),
      .hit(frame_hit[f])
    );
  end

  // Detection does not look at the power state, so it keeps running in
  // the D3hot low-power state.
  assign wake_event = (link_change & s.dev_cfg[CFG_LINK_BIT])
    | (wake_packet_hit & pkt_en)
    | ((|frame_hit) & frame_en);

  // -----------------------------------------------------------------------
  // Next state.
  // -----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rd_data = '0;

    // Link level passes two flops before the edge detector sees it.
    next_s.link_meta = link_status;
    next_s.link_sync = s.link_meta;
    next_s.link_prev = s.link_sync;
    next_s.link_primed = 1'b1;

    // Byte index of the current received frame, held at the limit.
    if (rx_start) begin
      next_s.rx_idx = '0;
    end else if (rx_valid && !length_over) begin
      next_s.rx_idx = s.rx_idx + PTR_STEP;
    end

    // Register writes.
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_POWER_CTRL_STATUS_REG: begin
          // Intermediate state codes leave the state unchanged.
          if (reg_wr_data[PM_STATE_LSB+1:PM_STATE_LSB] == WKPME_D0 ||
              reg_wr_data[PM_STATE_LSB+1:PM_STATE_LSB] == WKPME_D3HOT) begin
            next_s.pstate = wkpme_pstate_e'(
              reg_wr_data[PM_STATE_LSB+1:PM_STATE_LSB]);
          end
          next_s.wake_en = reg_wr_data[PM_EN_BIT];
          if (reg_wr_data[PM_STATUS_BIT]) begin
            next_s.wake_status = 1'b0;
          end
        end
        ADDR_DEV_CFG: next_s.dev_cfg = reg_wr_data;
        ADDR_OP_MODE: next_s.op_mode = reg_wr_data;
        ADDR_PORT_SEL: next_s.port_sel = reg_wr_data;
        ADDR_PORT_DATA: begin
          if (fifo_test) begin
            unique case (port)
              PORT_TX: begin
                next_s.tx_mem[s.tx_wp] = reg_wr_data;
                next_s.tx_wp = s.tx_wp + PTR_STEP;
              end
              PORT_RX: begin
                next_s.rx_mem[s.rx_wp] = reg_wr_data;
                next_s.rx_wp = s.rx_wp + PTR_STEP;
              end
              PORT_DIAG: begin
                // Each set bit except bit 4 acts on every write; no pointer stays held, so writing zero only clears the readback.
                next_s.diag = reg_wr_data[6:0];
                if (reg_wr_data[DIAG_CLR_TX_WP]) begin
                  next_s.tx_wp = '0;
                end
                if (reg_wr_data[DIAG_CLR_TX_RP]) begin
                  next_s.tx_rp = '0;
                end
                if (reg_wr_data[DIAG_CLR_RX_WP]) begin
                  next_s.rx_wp = '0;
                end
                if (reg_wr_data[DIAG_CLR_RX_RP]) begin
                  next_s.rx_rp = '0;
                end
                if (reg_wr_data[DIAG_SET_TX_WP]) begin
                  next_s.tx_wp = PTR_HALF;
                end
                if (reg_wr_data[DIAG_SET_RX_WP]) begin
                  next_s.rx_wp = PTR_HALF;
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; data stand in the next cycle only.
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_POWER_CTRL_STATUS_REG: begin
          next_s.rd_data[PM_STATE_LSB+1:PM_STATE_LSB] = s.pstate;
          next_s.rd_data[PM_EN_BIT] = s.wake_en;
          next_s.rd_data[PM_STATUS_BIT] = s.wake_status;
        end
        ADDR_DEV_CFG: next_s.rd_data = s.dev_cfg;
        ADDR_OP_MODE: next_s.rd_data = s.op_mode;
        ADDR_PORT_SEL: next_s.rd_data = s.port_sel;
        ADDR_PORT_DATA: begin
          if (fifo_test) begin
            unique case (port)
              PORT_TX: begin
                next_s.rd_data = s.tx_mem[s.tx_rp];
                next_s.tx_rp = s.tx_rp + PTR_STEP;
              end
              PORT_RX: begin
                next_s.rd_data = s.rx_mem[s.rx_rp];
                next_s.rx_rp = s.rx_rp + PTR_STEP;
              end
              PORT_DIAG: next_s.rd_data[6:0] = s.diag;
              default: begin
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end

    // A wake event in the cycle of a status clear still sets the status.
    if (wake_event) begin
      next_s.wake_status = 1'b1;
    end

    // Pin is driven low while enabled status stands; no bus timing involved.
    next_s.pme_out = 1'b0;
    next_s.pme_oe = ~(next_s.wake_en & next_s.wake_status);
  end

  // -----------------------------------------------------------------------
  // Registers.
  // -----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.pstate <= WKPME_D0;
      s.dev_cfg <= DEV_CFG_RST;
      s.op_mode <= OP_MODE_RST;
      s.port_sel <= PORT_SEL_RST;
      s.pme_oe <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rd_data = s.rd_data;
  assign power_state = s.pstate;
  assign pme_n_out = s.pme_out;
  assign pme_n_oe = s.pme_oe;

endmodule

// ===== dv/wkpme_rx_model.sv
// Receive path model: frames, wake packet pulses, link pin.
// Assumes tb_top calls its tasks; shares mclk with the block.
`timescale 1ns/1ps
module wkpme_rx_model (
  // Clock.
  input wire logic mclk,
  // Receive stream and events.
  output logic rx_start,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic wake_packet_hit,
  output logic link_status
);
  initial begin
    {rx_start, rx_valid, rx_end, wake_packet_hit, link_status} = 5'h0;
    rx_data = 8'h0;
  end
  // Sends three bytes, low byte first; the bus then shows garbage.
  task automatic send(input logic [23:0] f);
    @(posedge mclk);
    rx_start <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk);
      rx_start <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= f[8*k +: 8];
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data <= ~f[23:16];
    rx_end <= 1'b1;
    @(posedge mclk);
    rx_end <= 1'b0;
  endtask
  task automatic pulse;
    @(posedge mclk);
    wake_packet_hit <= 1'b1;
    @(posedge mclk);
    wake_packet_hit <= 1'b0;
  endtask
  task automatic flip;
    @(posedge mclk);
    link_status <= ~link_status;
  endtask
endmodule

// ===== dv/wkpme_checker.sv
// Port checker of the wake event block.
// Assumes it is bound into wkpme_top.
`timescale 1ns/1ps
module wkpme_checker (
  // Clock, reset, register port.
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rd_data,
  // Events.
  input wire logic link_status,
  input wire logic nv_wake_packet_en,
  input wire logic wake_packet_hit,
  // Power management.
  input wire wkpme_pkg::wkpme_pstate_e power_state,
  input wire logic pme_n_out,
  input wire logic pme_n_oe
);
  import wkpme_pkg::*;
  logic en_m;
  logic [31:0] cfg_m;
  logic pm_wr;
  assign pm_wr = reg_wr && reg_addr == ADDR_POWER_CTRL_STATUS_REG;
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_m <= 1'b0;
      cfg_m <= DEV_CFG_RST;
    end else begin
      if (pm_wr) en_m <= reg_wr_data[PM_EN_BIT];
      if (reg_wr && reg_addr == ADDR_DEV_CFG) cfg_m <= reg_wr_data;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence pm_write;
    pm_wr;
  endsequence
  sequence link_moved;
    $changed(link_status) && en_m && cfg_m[CFG_LINK_BIT];
  endsequence
  pme_data_a: assert property (pme_n_out == 1'b0)
    else $error("pme data not low");
  reset_idle_a: assert property ($past(rst) |-> !power_state && pme_n_oe)
    else $error("bad state after reset");
  state_legal_a: assert property (power_state inside {WKPME_D0, WKPME_D3HOT})
    else $error("illegal power state");
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rd_data == 32'h0)
    else $error("read data outside slot");
  pme_hold_a: assert property (!pme_n_oe && !pm_wr |=> !pme_n_oe)
    else $error("pme released early");
  pme_release_a: assert property ($rose(pme_n_oe) |-> $past(pm_wr))
    else $error("pme released without write");
  no_enable_a: assert property (!en_m && pme_n_oe |=> pm_write or pme_n_oe)
    else $error("pme while disabled");
  pkt_wake_a: assert property (wake_packet_hit && en_m && !pm_wr
    && (cfg_m[CFG_PKT_BIT] || nv_wake_packet_en) |=> !pme_n_oe)
    else $error("packet wake missed");
  link_wake_a: assert property (link_moved |-> ##[1:4] !pme_n_oe)
    else $error("link wake missed");
endmodule
bind wkpme_top wkpme_checker wkpme_checker_i (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .link_status(link_status),
  .nv_wake_packet_en(nv_wake_packet_en),
  .wake_packet_hit(wake_packet_hit), .power_state(power_state),
  .pme_n_out(pme_n_out), .pme_n_oe(pme_n_oe));

// ===== dv/tb_top.sv
// Self-checking bench of the wake event block.
// Assumes the receive model and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import wkpme_pkg::*;
  logic mclk, rst, reg_wr, reg_rd, nv_wake_packet_en;
  logic link_status, wake_packet_hit, rx_start, rx_valid, rx_end;
  logic [7:0] reg_addr, rx_data;
  logic [31:0] reg_wr_data, reg_rd_data;
  wkpme_pstate_e power_state;
  logic pme_n_out, pme_n_oe;
  int n_mismatch, total_checks, cycles;
  logic [7:0] regs[6] = '{ADDR_OP_MODE, ADDR_DEV_CFG, ADDR_POWER_CTRL_STATUS_REG,
    ADDR_PORT_SEL, ADDR_PORT_DATA, 8'h7c};
  logic [1:0] sv[4] = '{2'h3, 2'h1, 2'h0, 2'h2};
  logic [1:0] se[4] = '{2'h3, 2'h3, 2'h0, 2'h0};
  wkpme_top wkpme_top_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rd_data(reg_rd_data), .link_status(link_status),
    .nv_wake_packet_en(nv_wake_packet_en),
    .wake_packet_hit(wake_packet_hit), .rx_start(rx_start),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .power_state(power_state), .pme_n_out(pme_n_out),
    .pme_n_oe(pme_n_oe));
  wkpme_rx_model wkpme_rx_model_i (.mclk(mclk), .rx_start(rx_start),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .wake_packet_hit(wake_packet_hit), .link_status(link_status));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  // --------
  // Tasks.
  // --------
  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("read data", reg_rd_data, exp);
  endtask
  task automatic pme(input logic e);
    @(negedge mclk);
    chk("pme enable", {31'h0, pme_n_oe}, {31'h0, e});
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // --------
  // Tests.
  // --------
  initial begin
    {rst, reg_wr, reg_rd, nv_wake_packet_en} = 4'h8;
    reg_addr = 8'h0;
    reg_wr_data = 32'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_POWER_CTRL_STATUS_REG, {30'h0, sv[i]});
      @(negedge mclk);
      chk("state", {30'h0, power_state}, {30'h0, se[i]});
    end
    nv_wake_packet_en <= 1'b1;
    wr(ADDR_POWER_CTRL_STATUS_REG, 32'h8000);
    wkpme_rx_model_i.pulse();
    pme(1'b1);
    rd(ADDR_POWER_CTRL_STATUS_REG, 32'h8000);
    wr(ADDR_POWER_CTRL_STATUS_REG, 32'h0100);
    repeat (5) @(posedge mclk);
    pme(1'b0);
    wr(ADDR_POWER_CTRL_STATUS_REG, 32'h8100);
    pme(1'b1);
    wkpme_rx_model_i.pulse();
    pme(1'b0);
    wr(ADDR_POWER_CTRL_STATUS_REG, 32'h8100);
    pme(1'b1);
    nv_wake_packet_en <= 1'b0;
    wr(ADDR_DEV_CFG, 32'h2000_0000);
    wkpme_rx_model_i.flip();
    repeat (6) @(posedge mclk);
    pme(1'b0);
    wr(ADDR_POWER_CTRL_STATUS_REG, 32'h0);
    pme(1'b1);
    wr(ADDR_PORT_SEL, 32'h1a8);
    wr(ADDR_PORT_DATA, 32'h55);
    rd(ADDR_PORT_DATA, 32'h0);
    wr(ADDR_OP_MODE, 32'h0600_0000);
    wr(ADDR_PORT_DATA, 32'h11);
    wr(ADDR_PORT_SEL, 32'h1c0);
    wr(ADDR_PORT_DATA, 32'h0f);
    rd(ADDR_PORT_DATA, 32'h0f);
    wr(ADDR_PORT_DATA, 32'h0);
    wr(ADDR_PORT_SEL, 32'h1a8);
    rd(ADDR_PORT_SEL, 32'h1a8);
    wr(ADDR_PORT_DATA, 32'haa);
    wr(ADDR_PORT_DATA, 32'hbb);
    rd(ADDR_PORT_DATA, 32'haa);
    rd(ADDR_PORT_DATA, 32'hbb);
    wr(ADDR_PORT_SEL, 32'h190);
    wr(ADDR_PORT_DATA, 32'h1);
    wr(ADDR_PORT_DATA, 32'h1);
    wr(ADDR_PORT_DATA, 32'h3);
    wr(ADDR_OP_MODE, 32'h0);
    wr(ADDR_DEV_CFG, 32'h1000_0000);
    wr(ADDR_POWER_CTRL_STATUS_REG, 32'h8103);
    wkpme_rx_model_i.send(24'hcc55aa);
    repeat (4) @(posedge mclk);
    pme(1'b1);
    wkpme_rx_model_i.send(24'hccbbaa);
    repeat (3) @(posedge mclk);
    pme(1'b0);
    rd(ADDR_POWER_CTRL_STATUS_REG, 32'h8103);
    close_out();
  end
endmodule
